// ===== src/bitmap_pkg.sv
// Package with register offsets, field positions and reset values
// for the video bit mapper and address select block.
// Assumes nothing of its surroundings; imported by the mapper and the bench.
package bitmap_pkg;

  // Register offsets on the control register port.
  localparam logic [7:0] REG_ADDR_FIRST  = 8'h00;
  localparam logic [7:0] REG_ADDR_SECOND = 8'h01;
  localparam logic [7:0] REG_MISC_CTRL   = 8'h0D;
  localparam int         RES_DIS_BIT     = 4;

  // Register values after reset, before the pins are sampled.
  localparam logic [7:0] ADDR_FIRST_RST  = 8'h80;
  localparam logic [7:0] ADDR_SECOND_RST = 8'h90;
  localparam logic       RES_DIS_RST     = 1'b0;

  // Codes of a three-level address pin.
  localparam logic [1:0] LEVEL_LOW  = 2'b00;
  localparam logic [1:0] LEVEL_HIGH = 2'b01;

  // Widths of the parallel input and of the captured word.
  localparam int LANE_BITS    = 28;
  localparam int WORD_W       = 33;
  localparam int PAYLOAD_W    = 32;
  localparam int FIFO_DEPTH   = 8;

  // Positions inside the captured word.
  localparam int W_AUX1 = 28;
  localparam int W_AUX2 = 29;
  localparam int W_SD   = 30;
  localparam int W_SCK  = 31;
  localparam int W_WS   = 32;

  // Positions inside the mapped payload word.
  localparam int P_SYNC_LO = 18;
  localparam int P_SYNC_HI = 20;
  localparam int P_EXT_LO  = 21;
  localparam int P_EXT_HI  = 26;
  localparam int P_RES     = 27;
  localparam int P_AUX2    = 28;
  localparam int P_SD      = 29;
  localparam int P_SCK     = 30;
  localparam int P_WS      = 31;
  localparam int P_COLOUR  = 18;

endpackage : bitmap_pkg

// ===== src/cdc_word_fifo.sv
// Dual-clock word FIFO with gray-coded pointers.
// Assumes DEPTH is a power of two and at least four.
`timescale 1ns/10ps
module cdc_word_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  // Common reset.
  input  wire logic             reset_i,
  // Filling side.
  input  wire logic             wr_clk_i,
  input  wire logic             wr_valid_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  output logic                  wr_ready_o,
  // Draining side.
  input  wire logic             rd_clk_i,
  input  wire logic             rd_ready_i,
  output logic                  rd_valid_o,
  output logic      [WIDTH-1:0] rd_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wbin_r, wgray_r, rbin_r, rgray_r;
  logic [AW:0] wq1_r, wq2_r, rq1_r, rq2_r;

  wire          wr_fire   = wr_valid_i && wr_ready_o;
  wire          rd_fire   = rd_valid_o && rd_ready_i;
  wire [AW:0]   wbin_nxt  = wbin_r + {{AW{1'b0}}, wr_fire};
  wire [AW:0]   rbin_nxt  = rbin_r + {{AW{1'b0}}, rd_fire};
  wire [AW:0]   wgray_nxt = (wbin_nxt >> 1) ^ wbin_nxt;
  wire [AW:0]   rgray_nxt = (rbin_nxt >> 1) ^ rbin_nxt;
  wire          full_nxt  = wgray_nxt == {~rq2_r[AW:AW-1], rq2_r[AW-2:0]};
  wire          empty_nxt = rgray_nxt == wq2_r;

  assign rd_data_o = mem_r[rbin_r[AW-1:0]];

  // Storage is written on the filling clock only.
  always_ff @(posedge wr_clk_i) begin
    if (wr_fire) begin
      mem_r[wbin_r[AW-1:0]] <= wr_data_i;
    end
  end

  // Write pointer and registered not-full flag.
  always_ff @(posedge wr_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wbin_r     <= '0;
      wgray_r    <= '0;
      rq1_r      <= '0;
      rq2_r      <= '0;
      wr_ready_o <= 1'b1;
    end else begin
      wbin_r     <= wbin_nxt;
      wgray_r    <= wgray_nxt;
      rq1_r      <= rgray_r;
      rq2_r      <= rq1_r;
      wr_ready_o <= !full_nxt;
    end
  end

  // Read pointer and registered not-empty flag.
  always_ff @(posedge rd_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rbin_r     <= '0;
      rgray_r    <= '0;
      wq1_r      <= '0;
      wq2_r      <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rbin_r     <= rbin_nxt;
      rgray_r    <= rgray_nxt;
      wq1_r      <= wgray_r;
      wq2_r      <= wq1_r;
      rd_valid_o <= !empty_nxt;
    end
  end

endmodule : cdc_word_fifo

// ===== src/pin_sync.sv
// Three-stage synchroniser for slow pin levels.
// Assumes the pins change slowly compared with the sampling clock.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Pin levels and their filtered copy.
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  wire  [WIDTH-1:0] agree;
  wire  [WIDTH-1:0] level_nxt;

  // A bit changes only once the second and third stages agree.
  assign agree     = ~(s2_r ^ s3_r);
  assign level_nxt = (agree & s3_r) | (~agree & level_o);

  // Shift chain; the first stage feeds only the second.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      level_o <= '0;
    end else begin
      s1_r    <= pin_i;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_o <= level_nxt;
    end
  end

endmodule : pin_sync

// ===== src/video_bit_mapper_addr_select.sv
// Input bit mapper, encryption coverage and device address select.
// Assumes a pixel clock on its own port, slow strap pins, and a control
// register port driven on the core clock by the control channel.
//
// Summary of operation
// - Three lanes give 21 input bits, four lanes 28 plus aux controls.
// - Three-lane mode ignores the fourth lane; positions 21 to 28 read zero.
// - Bits 0-17 are red, green, blue 0-5 and all may be encrypted.
// - Four-lane bits 21-26 carry colour bits 6 and 7, also encrypted.
// - Sync and enable bits 18-20 and aux controls are never encrypted.
// - With audio disabled the audio data pin is an unencrypted control.
// - With audio enabled the audio data pin is encrypted.
// - Encryption off sends the same mapping with no encrypted positions.
// - Registers 0x00 and 0x01 hold both addresses and are writable.
// - Address bit 4 is 0 for this end and 1 for the partner.
// - Default address bits 7:6 and 3:2 follow the two address pins.
// - Address pins are sampled only after reset, power-up or power-down exit.
// - Bus width select low gives three lanes, high gives four.
// - Position 27 is reserved bit unless register 0x0D bit 4 is set.
`timescale 1ns/10ps
module video_bit_mapper_addr_select
  import bitmap_pkg::*;
(
  // Core clock and reset.
  input  wire logic                            core_clk_i,
  input  wire logic                            reset_i,
  // Pixel clock domain inputs.
  input  wire logic                            pixel_clock_in_i,
  input  wire logic [bitmap_pkg::LANE_BITS-1:0] lane_bits_i,
  input  wire logic                            aux_control_1_i,
  input  wire logic                            aux_control_2_i,
  input  wire logic                            audio_data_or_ctrl0_i,
  input  wire logic                            audio_bit_clk_i,
  input  wire logic                            audio_word_sel_i,
  output logic                                 capture_ready_o,
  // Strap and power pins.
  input  wire logic                            bus_width_select_i,
  input  wire logic                            power_down_n_i,
  input  wire logic [1:0]                      addr_pin_high_i,
  input  wire logic [1:0]                      addr_pin_low_i,
  // Settings from the control logic.
  input  wire logic                            audio_enable_setting_i,
  input  wire logic                            encrypt_enable_i,
  // Control register port.
  input  wire logic                            reg_wr_i,
  input  wire logic                            reg_rd_i,
  input  wire logic [7:0]                      reg_addr_i,
  input  wire logic [7:0]                      reg_wdata_i,
  output logic      [7:0]                      reg_rdata_o,
  // Mapped payload toward the serial framer.
  output logic [bitmap_pkg::PAYLOAD_W-1:0]     payload_o,
  output logic [bitmap_pkg::PAYLOAD_W-1:0]     encrypt_mask_o,
  output logic                                 payload_valid_o,
  input  wire logic                            payload_ready_i
);

  import bitmap_pkg::*;

  // Pixel clock capture stage.
  logic [WORD_W-1:0] capt_r;
  logic              capt_valid_r;

  // Core side state.
  logic [7:0]        addr_first_r;
  logic [7:0]        addr_second_r;
  logic              res_dis_r;
  logic              power_prev_r;
  logic [5:0]        straps;
  logic [WORD_W-1:0] rd_word;
  logic              rd_valid;

  // Each rising pixel clock edge captures all lanes, aux and audio pins.
  always_ff @(posedge pixel_clock_in_i or posedge reset_i) begin
    if (reset_i) begin
      capt_r       <= '0;
      capt_valid_r <= 1'b0;
    end else begin
      capt_r       <= {audio_word_sel_i, audio_bit_clk_i,
                       audio_data_or_ctrl0_i, aux_control_2_i,
                       aux_control_1_i, lane_bits_i};
      capt_valid_r <= 1'b1;
    end
  end

  // Words cross to the core clock through the FIFO; full drops words and clears capture_ready_o.
  wire rd_take;

  cdc_word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .reset_i    (reset_i),
    .wr_clk_i   (pixel_clock_in_i),
    .wr_valid_i (capt_valid_r),
    .wr_data_i  (capt_r),
    .wr_ready_o (capture_ready_o),
    .rd_clk_i   (core_clk_i),
    .rd_ready_i (rd_take),
    .rd_valid_o (rd_valid),
    .rd_data_o  (rd_word)
  );

  // Strap pins pass three stages before use.
  pin_sync #(
    .WIDTH (6)
  ) u_straps (
    .clk_i   (core_clk_i),
    .reset_i (reset_i),
    .pin_i   ({bus_width_select_i, power_down_n_i,
               addr_pin_high_i, addr_pin_low_i}),
    .level_o (straps)
  );

  // Named strap levels.
  wire       four_lane = straps[5];
  wire       power_on  = straps[4];
  wire [1:0] pin_high  = straps[3:2];
  wire [1:0] pin_low   = straps[1:0];

  // Power-up and power-down exit both show as a rising power level.
  wire wake = power_on && !power_prev_r;

  // Three-level pin decode into address bits 7:6 and 3:2.
  wire [1:0] hi_bits = (pin_high == LEVEL_LOW)  ? 2'b10 :
                       (pin_high == LEVEL_HIGH) ? 2'b11 : 2'b01;
  wire [1:0] lo_bits = (pin_low == LEVEL_LOW)   ? 2'b00 :
                       (pin_low == LEVEL_HIGH)  ? 2'b01 : 2'b10;

  // Bit 4 tells this end from the partner; bits 5, 1 and 0 are zero.
  wire [7:0] dflt_first  = {hi_bits, 1'b0, 1'b0, lo_bits, 2'b00};
  wire [7:0] dflt_second = {hi_bits, 1'b0, 1'b1, lo_bits, 2'b00};

  // Register write decode.
  wire wr_first  = reg_wr_i && (reg_addr_i == REG_ADDR_FIRST);
  wire wr_second = reg_wr_i && (reg_addr_i == REG_ADDR_SECOND);
  wire wr_misc   = reg_wr_i && (reg_addr_i == REG_MISC_CTRL);

  // Next register values; a wake reload takes precedence over a write.
  wire [7:0] addr_first_nxt  = wake      ? dflt_first  :
                               wr_first  ? reg_wdata_i :
                                           addr_first_r;
  wire [7:0] addr_second_nxt = wake      ? dflt_second :
                               wr_second ? reg_wdata_i :
                                           addr_second_r;
  wire       res_dis_nxt     = wr_misc ? reg_wdata_i[RES_DIS_BIT]
                                       : res_dis_r;

  // Read data; unmapped offsets and reserved bits read as zero.
  wire [7:0] misc_rd  = {3'b000, res_dis_r, 4'h0};
  wire [7:0] rd_mux   = (reg_addr_i == REG_ADDR_FIRST)  ? addr_first_r :
                        (reg_addr_i == REG_ADDR_SECOND) ? addr_second_r :
                        (reg_addr_i == REG_MISC_CTRL)   ? misc_rd : 8'h00;

  // Address and control registers.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      addr_first_r  <= ADDR_FIRST_RST;
      addr_second_r <= ADDR_SECOND_RST;
      res_dis_r     <= RES_DIS_RST;
      power_prev_r  <= 1'b0;
      reg_rdata_o   <= 8'h00;
    end else begin
      addr_first_r  <= addr_first_nxt;
      addr_second_r <= addr_second_nxt;
      res_dis_r     <= res_dis_nxt;
      power_prev_r  <= power_on;
      reg_rdata_o   <= reg_rd_i ? rd_mux : reg_rdata_o;
    end
  end

  // Captured word fields.
  wire [LANE_BITS-1:0] lanes = rd_word[LANE_BITS-1:0];
  wire aux1 = rd_word[W_AUX1];
  wire aux2 = rd_word[W_AUX2];

  // Fourth-lane positions; all zero in three-lane mode.
  wire [5:0] ext_colour = four_lane ? lanes[P_EXT_HI:P_EXT_LO]
                                    : 6'h00;
  wire       pos27      = four_lane && (res_dis_r ? aux1
                                                  : lanes[P_RES]);
  wire       pos28      = four_lane && aux2;

  // Mapped payload: colour, sync, extra colour, aux and audio.
  wire [PAYLOAD_W-1:0] payload_nxt = {rd_word[W_WS],
                                      rd_word[W_SCK],
                                      rd_word[W_SD],
                                      pos28, pos27,
                                      ext_colour,
                                      lanes[P_SYNC_HI:0]};

  // Encryption coverage; sync, aux, clock and word select stay clear.
  wire [5:0]  ext_mask  = four_lane ? 6'h3f : 6'h00;
  wire [PAYLOAD_W-1:0] mask_on = {2'b00,
                                  audio_enable_setting_i,
                                  2'b00,
                                  ext_mask,
                                  3'b000,
                                  {P_COLOUR{1'b1}}};
  wire [PAYLOAD_W-1:0] mask_nxt = encrypt_enable_i ? mask_on
                                                   : '0;

  // Output stage takes a word when empty or when the framer accepts.
  assign rd_take = rd_valid && (!payload_valid_o || payload_ready_i);
  wire   valid_nxt = rd_take || (payload_valid_o && !payload_ready_i);

  // Payload output registers.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      payload_o       <= '0;
      encrypt_mask_o  <= '0;
      payload_valid_o <= 1'b0;
    end else begin
      payload_o       <= rd_take ? payload_nxt : payload_o;
      encrypt_mask_o  <= rd_take ? mask_nxt : encrypt_mask_o;
      payload_valid_o <= valid_nxt;
    end
  end

  // Checks on the core clock domain.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // A word taken from the FIFO then stands at the output.
  sequence s_take;
    rd_take ##1 payload_valid_o;
  endsequence

  property p_three_lane;
    !four_lane ##0 s_take |-> payload_o[P_AUX2:P_EXT_LO] == 8'h00;
  endproperty
  a_three_lane: assert property (p_three_lane)
    else $error("fourth lane leaked in three-lane mode");

  property p_colour_map;
    rd_take |=> payload_o[P_SYNC_HI:0] == $past(rd_word[P_SYNC_HI:0]);
  endproperty
  a_colour_map: assert property (p_colour_map)
    else $error("colour or sync bits mis-mapped");

  property p_colour_enc;
    rd_take && encrypt_enable_i |=> encrypt_mask_o[17:0] == 18'h3_ffff;
  endproperty
  a_colour_enc: assert property (p_colour_enc)
    else $error("colour bits not covered by encryption");

  property p_ext_enc;
    rd_take && encrypt_enable_i && four_lane
      |=> encrypt_mask_o[P_EXT_HI:P_EXT_LO] == 6'h3f;
  endproperty
  a_ext_enc: assert property (p_ext_enc)
    else $error("extra colour bits not encrypted");

  property p_never_enc;
    payload_valid_o |-> encrypt_mask_o[P_SYNC_HI:P_SYNC_LO] == 3'b000
                        && encrypt_mask_o[P_AUX2:P_RES] == 2'b00;
  endproperty
  a_never_enc: assert property (p_never_enc)
    else $error("sync or aux control marked for encryption");

  property p_audio_enc;
    rd_take && encrypt_enable_i
      |=> encrypt_mask_o[P_SD] == $past(audio_enable_setting_i);
  endproperty
  a_audio_enc: assert property (p_audio_enc)
    else $error("audio data encryption does not follow audio enable");

  property p_ctrl0_clear;
    rd_take && !audio_enable_setting_i |=> !encrypt_mask_o[P_SD];
  endproperty
  a_ctrl0_clear: assert property (p_ctrl0_clear)
    else $error("control input on audio pin was encrypted");

  property p_enc_off;
    rd_take && !encrypt_enable_i |=> encrypt_mask_o == '0;
  endproperty
  a_enc_off: assert property (p_enc_off)
    else $error("encryption disabled but mask not clear");

  property p_res_sel;
    rd_take && four_lane && res_dis_r |=> payload_o[P_RES] == $past(aux1);
  endproperty
  a_res_sel: assert property (p_res_sel)
    else $error("aux control 1 not placed at position 27");

  property p_addr_write;
    wr_first && !wake |=> addr_first_r == $past(reg_wdata_i);
  endproperty
  a_addr_write: assert property (p_addr_write)
    else $error("address register write lost");

  property p_addr_hold;
    !wake && !wr_first |=> $stable(addr_first_r);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address changed without wake or write");

  property p_addr_dflt;
    wake |=> addr_second_r == (addr_first_r | 8'h10) && !addr_first_r[4];
  endproperty
  a_addr_dflt: assert property (p_addr_dflt)
    else $error("default addresses differ in more than bit 4");

  // Fourth-lane colour bits reach their own positions unchanged.
  property p_ext_map;
    four_lane ##0 s_take
      |-> payload_o[P_EXT_HI:P_EXT_LO] == $past(lanes[P_EXT_HI:P_EXT_LO]);
  endproperty
  a_ext_map: assert property (p_ext_map)
    else $error("extra colour bits mis-mapped in four-lane mode");

  property p_ext_clear;
    rd_take && !four_lane |=> encrypt_mask_o[P_EXT_HI:P_EXT_LO] == 6'h00;
  endproperty
  a_ext_clear: assert property (p_ext_clear)
    else $error("absent fourth lane marked for encryption");

  property p_res_dflt;
    rd_take && four_lane && !res_dis_r
      |=> payload_o[P_RES] == $past(lanes[P_RES]);
  endproperty
  a_res_dflt: assert property (p_res_dflt)
    else $error("reserved bit not passed at position 27");

  property p_aux2_map;
    rd_take && four_lane |=> payload_o[P_AUX2] == $past(aux2);
  endproperty
  a_aux2_map: assert property (p_aux2_map)
    else $error("aux control 2 not placed at position 28");

  // Audio data, bit clock and word select keep their order in both modes.
  property p_audio_map;
    rd_take |=> payload_o[P_WS:P_SD] == $past(rd_word[W_WS:W_SD]);
  endproperty
  a_audio_map: assert property (p_audio_map)
    else $error("audio pins mis-mapped");

  property p_second_write;
    wr_second && !wake |=> addr_second_r == $past(reg_wdata_i);
  endproperty
  a_second_write: assert property (p_second_write)
    else $error("partner address register write lost");

  // An open pin gives its own code in each half of the default address.
  property p_high_open;
    wake && pin_high[1] |=> addr_first_r[7:6] == 2'b01;
  endproperty
  a_high_open: assert property (p_high_open)
    else $error("open high address pin gave wrong default");

  property p_low_open;
    wake && pin_low[1] |=> addr_first_r[3:2] == 2'b10;
  endproperty
  a_low_open: assert property (p_low_open)
    else $error("open low address pin gave wrong default");

endmodule : video_bit_mapper_addr_select

// ===== verification/video_bit_mapper_addr_select_bench.sv
// Self-checking bench for the bit mapper and address select block.
// Assumes the source model file and the design files are compiled first.
`timescale 1ns/10ps
module video_bit_mapper_addr_select_bench;
  import bitmap_pkg::*;

  typedef struct packed {
    logic        bus_width_select;
    logic        aud;
    logic        enc;
    logic        rdis;
    logic [31:0] pay;
    logic [31:0] mask;
  } row_t;

  // Settings beside the payload and coverage mask that they should give.
  row_t rows [0:4] = '{
    '{1'b1, 1'b1, 1'b1, 1'b0, 32'hBDA5_A5A5, 32'h27E3_FFFF},
    '{1'b1, 1'b0, 1'b1, 1'b1, 32'hB5A5_A5A5, 32'h07E3_FFFF},
    '{1'b0, 1'b1, 1'b1, 1'b0, 32'hA005_A5A5, 32'h2003_FFFF},
    '{1'b0, 1'b0, 1'b0, 1'b0, 32'hA005_A5A5, 32'h0000_0000},
    '{1'b1, 1'b1, 1'b0, 1'b1, 32'hB5A5_A5A5, 32'h0000_0000}};

  logic        core_clk_i = 1'b0;
  logic        reset_i    = 1'b1;
  logic        pd_n       = 1'b1;
  logic        bus_width_select        = 1'b1;
  logic        aud        = 1'b1;
  logic        enc        = 1'b1;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic        ready      = 1'b1;
  logic        run        = 1'b1;
  logic [1:0]  ahi        = 2'b10;
  logic [1:0]  alo        = 2'b01;
  logic [7:0]  raddr      = 8'h00;
  logic [7:0]  wdata      = 8'h00;
  logic [4:0]  side       = 5'b10_110;
  logic [27:0] lanes      = 28'hDA5_A5A5;
  logic        pclk;
  logic [27:0] lane_bits;
  logic [4:0]  side_pins;
  logic        cap_rdy;
  logic [7:0]  rdata;
  logic [31:0] payload;
  logic [31:0] mask;
  logic [31:0] held;
  logic        pvalid;
  int          error_cnt   = 0;
  int          comparisons = 0;
  int          n;

  // Core clock of 25 ns.
  always begin
    #12.5 core_clk_i = ~core_clk_i;
  end

  video_source_model src (
    .run_i       (run),
    .lanes_i     (lanes),
    .side_i      (side),
    .pixel_clk_o (pclk),
    .lane_bits_o (lane_bits),
    .side_o      (side_pins)
  );

  // The side pins carry ws, sck, audio data, aux 2 and aux 1 from the top.
  video_bit_mapper_addr_select dut (
    .core_clk_i             (core_clk_i),
    .reset_i                (reset_i),
    .pixel_clock_in_i       (pclk),
    .lane_bits_i            (lane_bits),
    .aux_control_1_i        (side_pins[0]),
    .aux_control_2_i        (side_pins[1]),
    .audio_data_or_ctrl0_i  (side_pins[2]),
    .audio_bit_clk_i        (side_pins[3]),
    .audio_word_sel_i       (side_pins[4]),
    .capture_ready_o        (cap_rdy),
    .bus_width_select_i     (bus_width_select),
    .power_down_n_i         (pd_n),
    .addr_pin_high_i        (ahi),
    .addr_pin_low_i         (alo),
    .audio_enable_setting_i (aud),
    .encrypt_enable_i       (enc),
    .reg_wr_i               (reg_wr),
    .reg_rd_i               (reg_rd),
    .reg_addr_i             (raddr),
    .reg_wdata_i            (wdata),
    .reg_rdata_o            (rdata),
    .payload_o              (payload),
    .encrypt_mask_o         (mask),
    .payload_valid_o        (pvalid),
    .payload_ready_i        (ready)
  );

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Compares one value and reports a difference at once.
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One-cycle write strobe on the register port.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_wr = 1'b1;
    raddr  = a;
    wdata  = d;
    @(negedge core_clk_i);
    reg_wr = 1'b0;
  endtask : reg_write

  // One-cycle read strobe; data is valid one cycle later.
  task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk_i);
    reg_rd = 1'b1;
    raddr  = a;
    @(negedge core_clk_i);
    reg_rd = 1'b0;
    check("register", {24'h0, e}, {24'h0, rdata});
  endtask : reg_read

  // Waits a bounded time for a payload word.
  task automatic wait_valid();
    n = 0;
    while (pvalid !== 1'b1 && n < 100) begin
      @(negedge core_clk_i);
      n++;
    end
    if (pvalid !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH payload_valid expected 1 seen %b", pvalid);
      end_of_test();
    end
  endtask : wait_valid

  initial begin
    repeat (16) @(negedge core_clk_i);
    reset_i = 1'b0;
    // Table of lane modes, audio and encryption settings.
    for (int i = 0; i < 5; i++) begin
      bus_width_select = rows[i].bus_width_select;
      aud = rows[i].aud;
      enc = rows[i].enc;
      reg_write(REG_MISC_CTRL, rows[i].rdis ? 8'h10 : 8'h00);
      repeat (60) @(negedge core_clk_i);
      wait_valid();
      check("payload", rows[i].pay, payload);
      check("mask", rows[i].mask, mask);
    end
    // Default addresses follow the pins sampled at power-up.
    reg_read(REG_ADDR_FIRST, 8'h44);
    reg_read(REG_ADDR_SECOND, 8'h54);
    ahi = LEVEL_LOW;
    alo = LEVEL_LOW;
    repeat (10) @(negedge core_clk_i);
    reg_read(REG_ADDR_FIRST, 8'h44);
    pd_n = 1'b0;
    repeat (10) @(negedge core_clk_i);
    pd_n = 1'b1;
    repeat (12) @(negedge core_clk_i);
    reg_read(REG_ADDR_FIRST, 8'h80);
    reg_read(REG_ADDR_SECOND, 8'h90);
    // Address registers are writable, back to back; gaps read zero.
    reg_write(REG_ADDR_FIRST, 8'h3C);
    reg_write(REG_ADDR_SECOND, 8'h2A);
    reg_read(REG_ADDR_FIRST, 8'h3C);
    reg_read(REG_ADDR_SECOND, 8'h2A);
    reg_read(8'h05, 8'h00);
    reg_write(REG_MISC_CTRL, 8'hFF);
    reg_read(REG_MISC_CTRL, 8'h10);
    // Stall the framer until the buffer refuses, holding the output.
    ready = 1'b0;
    wait_valid();
    held = payload;
    n = 0;
    while (cap_rdy !== 1'b0 && n < 400) begin
      @(negedge core_clk_i);
      n++;
    end
    check("capture_ready", 32'h0, {31'h0, cap_rdy});
    check("held payload", held, payload);
    check("held valid", 32'h1, {31'h0, pvalid});
    // Stop the pixel clock and drain until empty.
    run = 1'b0;
    repeat (30) @(negedge core_clk_i);
    ready = 1'b1;
    n = 0;
    while (pvalid === 1'b1 && n < 100) begin
      @(negedge core_clk_i);
      n++;
    end
    check("drained valid", 32'h0, {31'h0, pvalid});
    check("drained count", 32'h1, {31'h0, n >= FIFO_DEPTH});
    run = 1'b1;
    repeat (30) @(negedge core_clk_i);
    check("refill ready", 32'h1, {31'h0, cap_rdy});
    // A mid-run reset clears the outputs but sets capture ready, then the pins are sampled again.
    ahi     = LEVEL_HIGH;
    alo     = 2'b10;
    reset_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    check("reset valid", 32'h0, {31'h0, pvalid});
    check("reset payload", 32'h0, payload);
    check("reset mask", 32'h0, mask);
    check("reset rdata", 32'h0, {24'h0, rdata});
    check("reset ready", 32'h1, {31'h0, cap_rdy});
    reset_i = 1'b0;
    reg_read(REG_ADDR_FIRST, ADDR_FIRST_RST);
    repeat (8) @(negedge core_clk_i);
    reg_read(REG_ADDR_FIRST, 8'hC8);
    reg_read(REG_ADDR_SECOND, 8'hD8);
    end_of_test();
  end
endmodule : video_bit_mapper_addr_select_bench

// ===== verification/video_source_model.sv
// Behavioural model of the graphics controller that feeds the mapper.
// Assumes the bench supplies the word to send and gates the clock.
`timescale 1ns/10ps
module video_source_model (
  // Control from the bench.
  input  wire logic        run_i,
  input  wire logic [27:0] lanes_i,
  input  wire logic [4:0]  side_i,
  // Pins toward the mapper.
  output logic             pixel_clk_o,
  output logic [27:0]      lane_bits_o,
  output logic [4:0]       side_o
);
  // The pixel clock stops low between bursts and runs at 8 MHz otherwise.
  initial begin
    pixel_clk_o = 1'b0;
    lane_bits_o = '0;
    side_o      = '0;
    #7;
    forever begin
      #62.5;
      if (run_i || pixel_clk_o) begin
        pixel_clk_o = ~pixel_clk_o;
      end
    end
  end

  // New data is launched on the falling edge, away from the capture edge.
  always @(negedge pixel_clk_o) begin
    lane_bits_o <= lanes_i;
    side_o      <= side_i;
  end
endmodule : video_source_model
